// >>> tcct_defs.svh
// Register offsets, field positions, reset values of the timer unit.
// Assumes a 16-bit register bus with byte addresses and two byte lanes.
`ifndef TCCT_DEFS_SVH
`define TCCT_DEFS_SVH
// Per-channel word offsets, channel n at byte address n * 16
`define TCCT_OFF_CTL     4'h0
`define TCCT_OFF_IO      4'h2
`define TCCT_OFF_CNT     4'h4
`define TCCT_OFF_GA      4'h6
`define TCCT_OFF_GB      4'h8
`define TCCT_OFF_GC      4'ha
`define TCCT_OFF_GD      4'hc
`define TCCT_OFF_RUNSYNC 6'h30
// Reset values
`define TCCT_TGR_RST     16'hffff
`define TCCT_CNT_RST     16'h0000
`define TCCT_BYTE_RST    8'h00
`define TCCT_RUN_RST     3'h0
`define TCCT_SYNC_RST    3'h0
// Field positions
`define TCCT_IO_CAP      0
`define TCCT_IO_INIT     3
`define TCCT_MD_BUFA     2
`define TCCT_MD_BUFB     3
`define TCCT_CTL_EXT     3
`define TCCT_EXT_BASE    6
`endif

// >>> tcct_pkg.sv
// Types shared by the timer unit.
// Assumes the register fields decode straight into these codes.
package tcct_pkg;
   typedef enum logic [1:0] {tcct_md_normal, tcct_md_pwm, tcct_md_phase,
                             tcct_md_spare} tcct_mode_t;
   typedef enum logic [2:0] {tcct_clr_none, tcct_clr_on_a, tcct_clr_on_b,
                             tcct_clr_sync, tcct_clr_r4, tcct_clr_r5,
                             tcct_clr_r6, tcct_clr_r7} tcct_clr_t;
endpackage : tcct_pkg

// >>> tcct_timer.sv
// Three-channel 16-bit capture/compare timer with its register file.
// Assumes one clock, a synchronous reset and a 16-bit bus master using
// even byte addresses; pins arrive from outside the clock domain.
`include "tcct_defs.svh"
`timescale 1ns/1ns
module tcct_timer (
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic [5:0]  bus_addr,
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   input  wire logic [1:0]  bus_be,
   input  wire logic [15:0] bus_wdata,
   output wire logic [15:0] bus_rdata,
   input  wire logic [5:0]  timer_capture_compare_pin_in,
   output wire logic [5:0]  timer_capture_compare_pin_out,
   output wire logic [5:0]  timer_capture_compare_pin_oe,
   input  wire logic [3:0]  external_count_clock_pin
);

   function automatic logic tcct_lvl(input logic [1:0] act,
                                     input logic       cur);
      tcct_lvl = (act == 2'h1) ? 1'b0 :
                 (act == 2'h2) ? 1'b1 :
                 (act == 2'h3) ? ~cur : cur;
   endfunction : tcct_lvl

   logic [9:0]  syn1_r, syn2_r, syn3_r, filt_r, filt_d_r;
   logic [2:0]  run_r, sync_r;
   logic [15:0] bus_rdata_r;
   logic [15:0] rd_ch [3];
   wire  [2:0]  wr_cnt_v;
   wire  [2:0]  clr_own_v;
   wire  [9:0]  in_all = {external_count_clock_pin,
                           timer_capture_compare_pin_in};
   // A change only counts once the second and third stages agree
   wire  [9:0]  agree    = ~(syn2_r ^ syn3_r);
   wire  [9:0]  filt_nxt = (agree & syn3_r) | (~agree & filt_r);
   wire  [9:0]  rise_v   = filt_r & ~filt_d_r;
   wire  [9:0]  fall_v   = ~filt_r & filt_d_r;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         syn1_r   <= 10'h000;
         syn2_r   <= 10'h000;
         syn3_r   <= 10'h000;
         filt_r   <= 10'h000;
         filt_d_r <= 10'h000;
      end
      else
      begin
         syn1_r   <= in_all;
         syn2_r   <= syn1_r;
         syn3_r   <= syn2_r;
         filt_r   <= filt_nxt;
         filt_d_r <= filt_r;
      end
   end

   // Run and sync selects share one word: run high byte, sync low byte
   wire rs_sel = bus_wr & (bus_addr == `TCCT_OFF_RUNSYNC);
   wire wr_run = rs_sel & bus_be[1];
   wire wr_syn = rs_sel & bus_be[0];

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         run_r  <= `TCCT_RUN_RST;
         sync_r <= `TCCT_SYNC_RST;
      end
      else
      begin
         if (wr_run)
            run_r <= bus_wdata[10:8];
         if (wr_syn)
            sync_r <= bus_wdata[2:0];
      end
   end

   wire preset_any   = |(wr_cnt_v & sync_r);
   wire sync_clr_any = |(clr_own_v & sync_r);

   for (genvar c = 0; c < 3; c++)
   begin : g_ch
      localparam int QA = `TCCT_EXT_BASE + 2 * ((c == 0) ? 0 : c - 1);
      logic [7:0]  ctl_r, mode_r, io_r;
      logic [15:0] cnt_r;
      logic [15:0] tgr_r   [4];
      logic [15:0] tgr_nxt [4];
      logic [3:0]  hit_prev_r;
      logic [1:0]  out_r, oe_r;
      wire  [3:0]  hit;
      wire  [1:0]  cap;
      tcct_pkg::tcct_mode_t mode;
      tcct_pkg::tcct_clr_t  clr;
      assign mode = tcct_pkg::tcct_mode_t'(mode_r[1:0]);
      assign clr  = tcct_pkg::tcct_clr_t'(ctl_r[2:0]);

      wire       sel   = (bus_addr[5:4] == 2'(c));
      wire [3:0] off   = bus_addr[3:0];
      wire       wr_hi = bus_wr & sel & bus_be[1];
      wire       wr_lo = bus_wr & sel & bus_be[0];
      wire       wr_w  = bus_wr & sel & (bus_be == 2'h3);
      wire       wr_ctl  = wr_hi & (off == `TCCT_OFF_CTL);
      wire       wr_mode = wr_lo & (off == `TCCT_OFF_CTL);
      wire       wr_io   = wr_hi & (off == `TCCT_OFF_IO);
      assign wr_cnt_v[c] = wr_w & (off == `TCCT_OFF_CNT);
      // channel 0 alone has the third and fourth registers
      wire [3:0] wr_g = {wr_w & (off == `TCCT_OFF_GD) & (c == 0),
                         wr_w & (off == `TCCT_OFF_GC) & (c == 0),
                         wr_w & (off == `TCCT_OFF_GB),
                         wr_w & (off == `TCCT_OFF_GA)};

      // only phase mode counts down; channel 0 never does
      wire       phase  = (mode == tcct_pkg::tcct_md_phase) & (c != 0);
      wire       pwm    = (mode == tcct_pkg::tcct_md_pwm);
      wire [1:0] buf_en = (c == 0) ?
                          {mode_r[`TCCT_MD_BUFB], mode_r[`TCCT_MD_BUFA]} :
                          2'h0;
      wire [1:0] is_cap = {io_r[4 + `TCCT_IO_CAP], io_r[`TCCT_IO_CAP]};

      wire q_step = (filt_r[QA] ^ filt_d_r[QA]) ^
                    (filt_r[QA + 1] ^ filt_d_r[QA + 1]);
      wire q_up   = filt_d_r[QA] ^ filt_r[QA + 1];
      wire tick   = run_r[c] & (phase ? q_step :
                    ctl_r[`TCCT_CTL_EXT] ? rise_v[`TCCT_EXT_BASE + c] :
                    1'b1);
      wire down   = phase & ~q_up;

      for (genvar k = 0; k < 4; k++)
      begin : g_reg
         // stopped counters never match; the pin holds its level
         assign hit[k] = run_r[c] & (cnt_r == tgr_r[k]) &
                         ~((k < 2) & is_cap[k % 2]);
      end
      // Edge of the match only: a slow external count would retrigger
      wire [3:0] mp = hit & ~hit_prev_r;
      assign cap[0] = is_cap[0] & ((rise_v[2 * c] & io_r[1]) |
                                   (fall_v[2 * c] & io_r[2]));
      assign cap[1] = is_cap[1] & ((rise_v[2 * c + 1] & io_r[5]) |
                                   (fall_v[2 * c + 1] & io_r[6]));
      wire [1:0] ev = cap | mp[1:0];

      assign clr_own_v[c] = ((clr == tcct_pkg::tcct_clr_on_a) & ev[0]) |
                            ((clr == tcct_pkg::tcct_clr_on_b) & ev[1]);
      wire clr_now = clr_own_v[c] | (sync_r[c] & sync_clr_any &
                     (clr == tcct_pkg::tcct_clr_sync));
      wire preset  = wr_cnt_v[c] | (sync_r[c] & preset_any);
      wire [15:0] cnt_nxt = preset ? bus_wdata :
                            clr_now ? `TCCT_CNT_RST :
                            !tick ? cnt_r :
                            down ? cnt_r - 16'h0001 : cnt_r + 16'h0001;

      assign tgr_nxt[0] = cap[0] ? cnt_r :
                          (buf_en[0] & mp[0]) ? tgr_r[2] :
                          wr_g[0] ? bus_wdata : tgr_r[0];
      assign tgr_nxt[1] = cap[1] ? cnt_r :
                          (buf_en[1] & mp[1]) ? tgr_r[3] :
                          wr_g[1] ? bus_wdata : tgr_r[1];
      assign tgr_nxt[2] = (buf_en[0] & cap[0]) ? tgr_r[0] :
                          wr_g[2] ? bus_wdata : tgr_r[2];
      assign tgr_nxt[3] = (buf_en[1] & cap[1]) ? tgr_r[1] :
                          wr_g[3] ? bus_wdata : tgr_r[3];

      wire       io_init = wr_io & ~run_r[c];
      wire [7:0] io_w    = bus_wdata[15:8];
      // PWM: first match drives the first pin by io_r[2:1], second match by io_r[6:5]
      wire [1:0] out_nxt;
      assign out_nxt[0] = io_init ? io_w[`TCCT_IO_INIT] :
                          (pwm & mp[1]) ? tcct_lvl(io_r[6:5], out_r[0]) :
                          mp[0] ? tcct_lvl(io_r[2:1], out_r[0]) : out_r[0];
      assign out_nxt[1] = io_init ? io_w[4 + `TCCT_IO_INIT] :
                          (~pwm & mp[1]) ? tcct_lvl(io_r[6:5], out_r[1]) :
                          out_r[1];

      always_ff @(posedge clk_sys)
      begin
         if (reset)
         begin
            ctl_r      <= `TCCT_BYTE_RST;
            mode_r     <= `TCCT_BYTE_RST;
            io_r       <= `TCCT_BYTE_RST;
            cnt_r      <= `TCCT_CNT_RST;
            tgr_r      <= '{default: `TCCT_TGR_RST};
            hit_prev_r <= 4'h0;
            out_r      <= 2'h0;
            oe_r       <= 2'h0;
         end
         else
         begin
            if (wr_ctl)
               ctl_r <= bus_wdata[15:8];
            if (wr_mode)
               mode_r <= bus_wdata[7:0];
            if (wr_io)
               io_r <= io_w;
            cnt_r      <= cnt_nxt;
            tgr_r      <= tgr_nxt;
            hit_prev_r <= hit;
            out_r      <= out_nxt;
            oe_r       <= {~is_cap[1] & ~pwm, ~is_cap[0]};
         end
      end

      assign rd_ch[c] =
         (off == `TCCT_OFF_CTL) ? {ctl_r, mode_r} :
         (off == `TCCT_OFF_IO)  ? {io_r, 8'h00} :
         (off == `TCCT_OFF_CNT) ? cnt_r :
         (off == `TCCT_OFF_GA)  ? tgr_r[0] :
         (off == `TCCT_OFF_GB)  ? tgr_r[1] :
         ((off == `TCCT_OFF_GC) && (c == 0)) ? tgr_r[2] :
         ((off == `TCCT_OFF_GD) && (c == 0)) ? tgr_r[3] : 16'h0000;
      assign timer_capture_compare_pin_out[2 * c +: 2] = out_r;
      assign timer_capture_compare_pin_oe[2 * c +: 2]  = oe_r;
   end

   wire [15:0] rd_nxt = (bus_addr == `TCCT_OFF_RUNSYNC) ?
                        {5'h00, run_r, 5'h00, sync_r} :
                        (bus_addr[5:4] != 2'h3) ? rd_ch[bus_addr[5:4]] :
                        16'h0000;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         bus_rdata_r <= 16'h0000;
      else
         bus_rdata_r <= bus_rd ? rd_nxt : 16'h0000;
   end
   assign bus_rdata = bus_rdata_r;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   sequence s_cap_buf;
      g_ch[0].cap[0] && g_ch[0].buf_en[0];
   endsequence

   a_tgr_reset_ones: assert property (disable iff (1'b0)
      reset |=> (g_ch[0].tgr_r[3] == 16'hffff) &&
                (g_ch[2].tgr_r[1] == 16'hffff))
      else $error("compare register not all ones after reset");
   a_stop_holds: assert property (
      (!run_r[1] && !g_ch[1].preset && !g_ch[1].clr_now)
      |=> g_ch[1].cnt_r == $past(g_ch[1].cnt_r))
      else $error("stopped counter moved");
   a_free_count_up: assert property (
      (run_r[0] && g_ch[0].mode_r == 8'h00 && g_ch[0].ctl_r == 8'h00 &&
       !g_ch[0].preset) |=> g_ch[0].cnt_r == $past(g_ch[0].cnt_r) + 16'h1)
      else $error("free-running counter did not count up");
   a_sync_preset: assert property (
      (wr_cnt_v[0] && sync_r[0] && sync_r[2])
      |=> g_ch[2].cnt_r == $past(bus_wdata))
      else $error("synchronous preset missed");
   a_sync_clear: assert property (
      (clr_own_v[0] && sync_r[0] && sync_r[1] && !preset_any &&
       g_ch[1].clr == tcct_pkg::tcct_clr_sync) |=> g_ch[1].cnt_r == 16'h0)
      else $error("synchronous clear missed");
   a_run_write: assert property (
      wr_run |=> run_r == $past(bus_wdata[10:8]))
      else $error("run register write lost");
   a_sync_write: assert property (
      wr_syn |=> sync_r == $past(bus_wdata[2:0]))
      else $error("sync register write lost");
   a_io_initial: assert property (
      (g_ch[0].wr_io && !run_r[0]) |=> ##1
      timer_capture_compare_pin_out[0] == $past(bus_wdata[11], 2))
      else $error("initial level not driven");
   a_buf_compare: assert property (
      (g_ch[0].mp[0] && g_ch[0].buf_en[0])
      |=> g_ch[0].tgr_r[0] == $past(g_ch[0].tgr_r[2]))
      else $error("buffer not copied on compare match");
   a_buf_capture: assert property (
      s_cap_buf |=> (g_ch[0].tgr_r[0] == $past(g_ch[0].cnt_r)) &&
                    (g_ch[0].tgr_r[2] == $past(g_ch[0].tgr_r[0])))
      else $error("capture buffer transfer wrong");
   a_byte_ignored: assert property (
      (g_ch[1].sel && bus_wr && bus_be != 2'h3 && !g_ch[1].cap[1] &&
       g_ch[1].off == `TCCT_OFF_GB) |=> $stable(g_ch[1].tgr_r[1]))
      else $error("byte write reached a word register");
   a_phase_up: assert property (
      (g_ch[1].phase && g_ch[1].tick && g_ch[1].q_up &&
       !g_ch[1].preset && !g_ch[1].clr_now)
      |=> g_ch[1].cnt_r == $past(g_ch[1].cnt_r) + 16'h1)
      else $error("quadrature up step wrong");

endmodule : tcct_timer

// >>> tcct_bus_model.sv
// Bus master model for the timer register port.
// Assumes one bench process calls wr and rd one after another.
`timescale 1ns/1ns
module tcct_bus_model (
   input  wire logic        clk_sys,
   input  wire logic [15:0] bus_rdata,
   output logic      [5:0]  bus_addr,
   output logic             bus_wr,
   output logic             bus_rd,
   output logic      [1:0]  bus_be,
   output logic      [15:0] bus_wdata
);
   initial
   begin
      bus_addr = 6'h00;
      bus_wr = 1'h0;
      bus_rd = 1'h0;
      bus_be = 2'h3;
      bus_wdata = 16'h0000;
   end

   task automatic wr(input logic [5:0] a, input logic [1:0] be,
                     input logic [15:0] d);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_be <= be;
      bus_wdata <= d;
      bus_wr <= 1'h1;
      @(posedge clk_sys);
      bus_wr <= 1'h0;
      // Stale values would hide a decode that ignores the strobe
      bus_addr <= ~a;
      bus_wdata <= ~d;
   endtask : wr

   task automatic rd(input logic [5:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_be <= 2'h3;
      bus_rd <= 1'h1;
      @(posedge clk_sys);
      bus_rd <= 1'h0;
      bus_addr <= ~a;
      @(posedge clk_sys);
      d = bus_rdata;
   endtask : rd
endmodule : tcct_bus_model

// >>> tcct_timer_tb.sv
// Self-checking bench for the three-channel timer.
// Assumes the bus model above and the timer's register map.
`timescale 1ns/1ns
module tcct_timer_tb;
   logic        clk_sys;
   logic        reset;
   logic [5:0]  bus_addr;
   logic        bus_wr;
   logic        bus_rd;
   logic [1:0]  bus_be;
   logic [15:0] bus_wdata;
   logic [15:0] bus_rdata;
   logic [5:0]  pin_in;
   logic [5:0]  pin_out;
   logic [5:0]  pin_oe;
   logic [3:0]  ext_clk;
   logic [15:0] va;
   logic [15:0] vb;
   int          n_mismatch;
   int          comparisons;
   logic [5:0]  ra [13] = '{6'h06, 6'h08, 6'h0a, 6'h0c, 6'h16, 6'h18,
      6'h26, 6'h28, 6'h04, 6'h14, 6'h24, 6'h30, 6'h1a};
   logic [1:0]  up_seq [4] = '{2'h2, 2'h3, 2'h1, 2'h0};

   tcct_timer uut (.clk_sys(clk_sys), .reset(reset),
      .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .timer_capture_compare_pin_in(pin_in),
      .timer_capture_compare_pin_out(pin_out),
      .timer_capture_compare_pin_oe(pin_oe),
      .external_count_clock_pin(ext_clk));

   tcct_bus_model bm (.clk_sys(clk_sys), .bus_rdata(bus_rdata),
      .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_be(bus_be), .bus_wdata(bus_wdata));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic rc(input logic [5:0] a, input logic [15:0] exp);
      logic [15:0] d;
      bm.rd(a, d);
      chk(d, exp);
   endtask : rc

   task automatic step(input logic [1:0] v);
      @(posedge clk_sys);
      ext_clk[1:0] <= v;
      // Leaves room for the three-flop input synchroniser
      repeat (8) @(posedge clk_sys);
   endtask : step

   task automatic conclude;
      if (n_mismatch == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude

   initial
   begin
      clk_sys = 1'h0;
      forever #2 clk_sys = ~clk_sys;
   end

   // The tests need well under 2000 cycles
   initial
   begin
      #100000;
      n_mismatch++;
      conclude();
   end

   initial
   begin
      n_mismatch = 0;
      comparisons = 0;
      reset = 1'h1;
      pin_in = 6'h00;
      ext_clk = 4'h0;
      repeat (5) @(posedge clk_sys);
      reset <= 1'h0;
      for (int i = 0; i < 13; i++)
         rc(ra[i], (i < 8) ? 16'hffff : 16'h0000);
      bm.wr(6'h30, 2'h3, 16'hffff);
      rc(6'h30, 16'h0707);
      bm.wr(6'h30, 2'h3, 16'h0000);
      bm.wr(6'h30, 2'h1, 16'hff03);
      rc(6'h30, 16'h0003);
      bm.wr(6'h06, 2'h1, 16'h0000);
      rc(6'h06, 16'hffff);
      bm.wr(6'h18, 2'h2, 16'h0000);
      rc(6'h18, 16'hffff);
      bm.wr(6'h04, 2'h3, 16'h1234);
      rc(6'h14, 16'h1234);
      // Channel 2 counted five cycles in the all-run window, unsynced since
      rc(6'h24, 16'h0005);
      bm.wr(6'h30, 2'h1, 16'h0000);
      bm.wr(6'h14, 2'h3, 16'h0100);
      rc(6'h04, 16'h1234);
      bm.wr(6'h30, 2'h2, 16'h0100);
      bm.rd(6'h04, va);
      bm.rd(6'h04, vb);
      chk(vb - va, 16'h0003);
      bm.wr(6'h30, 2'h2, 16'h0000);
      bm.rd(6'h04, va);
      repeat (10) @(posedge clk_sys);
      bm.rd(6'h04, vb);
      chk(vb, va);
      bm.wr(6'h02, 2'h3, 16'h0800);
      repeat (2) @(posedge clk_sys);
      chk({14'h0, pin_oe[0], pin_out[0]}, 16'h0003);
      bm.wr(6'h00, 2'h1, 16'h0004);
      bm.wr(6'h0a, 2'h3, 16'h0020);
      bm.wr(6'h06, 2'h3, 16'h0005);
      bm.wr(6'h04, 2'h3, 16'h0000);
      bm.wr(6'h02, 2'h3, 16'h0400);
      repeat (2) @(posedge clk_sys);
      chk({14'h0, pin_oe[0], pin_out[0]}, 16'h0002);
      bm.wr(6'h30, 2'h2, 16'h0100);
      repeat (20) @(posedge clk_sys);
      bm.wr(6'h30, 2'h2, 16'h0000);
      chk({14'h0, pin_oe[0], pin_out[0]}, 16'h0003);
      rc(6'h06, 16'h0020);
      repeat (10) @(posedge clk_sys);
      chk({14'h0, pin_oe[0], pin_out[0]}, 16'h0003);
      bm.wr(6'h02, 2'h3, 16'h0200);
      repeat (2) @(posedge clk_sys);
      chk({14'h0, pin_oe[0], pin_out[0]}, 16'h0002);
      bm.wr(6'h10, 2'h1, 16'h0002);
      bm.wr(6'h30, 2'h2, 16'h0200);
      for (int i = 0; i < 4; i++)
         step(up_seq[i]);
      rc(6'h14, 16'h0104);
      for (int i = 0; i < 4; i++)
         step(up_seq[(6 - i) % 4]);
      rc(6'h14, 16'h0100);
      bm.wr(6'h30, 2'h2, 16'h0000);
      bm.wr(6'h10, 2'h3, 16'h0300);
      bm.wr(6'h00, 2'h2, 16'h0100);
      bm.wr(6'h30, 2'h1, 16'h0003);
      bm.wr(6'h04, 2'h3, 16'h0000);
      rc(6'h14, 16'h0000);
      bm.wr(6'h30, 2'h2, 16'h0200);
      repeat (4) @(posedge clk_sys);
      // Channel 1 runs ahead until the channel 0 match clears both
      bm.wr(6'h30, 2'h2, 16'h0300);
      repeat (40) @(posedge clk_sys);
      bm.wr(6'h30, 2'h2, 16'h0000);
      bm.rd(6'h04, va);
      rc(6'h14, va);
      chk({15'h0, va < 16'h0020}, 16'h0001);
      bm.wr(6'h02, 2'h2, 16'h0300);
      @(posedge clk_sys);
      pin_in[0] <= 1'h1;
      repeat (10) @(posedge clk_sys);
      chk({14'h0, pin_oe[0], pin_out[0]}, 16'h0000);
      rc(6'h06, va);
      rc(6'h0a, 16'h0020);
      rc(6'h14, 16'h0000);
      conclude();
   end
endmodule : tcct_timer_tb
